// >>> shared/mrso_pkg.sv
package mrso_pkg;

  // ****************************************
  // Widths, reset values and register offsets
  // ****************************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int PC_W = 11;
  localparam int PAGE_W = 3;
  localparam int WORD_W = 16;
  localparam logic [DATA_W-1:0] BYTE_ONES = 8'hff;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] WREG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] TABLE_POINTER_RESET = 8'h00;
  localparam logic [DATA_W-1:0] TABLE_READ_HIGH_BYTE_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 11'h000;
  // Avalon-MM word offsets (byte addresses).
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_OPERAND = 4'h4;
  localparam logic [3:0] OFS_WREG = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;
  // Control word fields.
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_BIT_LSB = 8;
  localparam int CTRL_IMM_LSB = 16;
  localparam int CTRL_GO_BIT = 31;
  // Status word fields.
  localparam int ST_C = 0;
  localparam int ST_Z = 1;
  localparam int ST_AC = 2;
  localparam int ST_OV = 3;
  localparam int ST_BUSY = 4;
  localparam int ST_SKIP = 5;

  // ****************************************
  // Operation codes
  // ****************************************
  typedef enum logic [4:0] {
    OP_NONE = 5'h00,
    OP_RLC = 5'h01,
    OP_RLC_W = 5'h02,
    OP_RR = 5'h03,
    OP_RR_W = 5'h04,
    OP_RRC = 5'h05,
    OP_RRC_W = 5'h06,
    OP_SUBB_W = 5'h07,
    OP_SUBB_M = 5'h08,
    OP_SUB_W = 5'h09,
    OP_SUB_M = 5'h0a,
    OP_SUB_I = 5'h0b,
    OP_DSZ_M = 5'h0c,
    OP_DSZ_W = 5'h0d,
    OP_SETB = 5'h0e,
    OP_SETBIT = 5'h0f,
    OP_ISZ_M = 5'h10,
    OP_ISZ_W = 5'h11,
    OP_SKBS = 5'h12,
    OP_SWAP_M = 5'h13,
    OP_SWAP_W = 5'h14,
    OP_SKZ = 5'h15,
    OP_CPSKZ = 5'h16,
    OP_TBRD = 5'h17,
    OP_SKBC = 5'h18
  } mrso_op_type;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_TBL = 4'b0100,
    ST_DUMMY = 4'b1000
  } mrso_state_type;

  // Status flags carried together.
  typedef struct packed {
    logic ov;
    logic ac;
    logic z;
    logic c;
  } mrso_flags_type;

  // Data memory access request.
  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mrso_mem_req_type;

endpackage

// >>> src/mrso_sub8.sv
`timescale 1ns/10ps
// Eight-bit subtractor with borrow-style carry and all four flags.
module mrso_sub8 (
  input wire logic [7:0] minuend, // Working register value.
  input wire logic [7:0] subtrahend, // Memory byte or immediate.
  input wire logic carry_in, // Carry; low means borrow one more.
  output logic [7:0] diff, // Difference.
  output mrso_pkg::mrso_flags_type flags // Resulting flags.
);
  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // Subtract as add of complement so carry set means no borrow.
  assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carry_in};
  assign low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
  assign diff = full_sum[7:0];
  assign flags.c = full_sum[8];
  assign flags.ac = low_sum[4];
  assign flags.z = (full_sum[7:0] == 8'h00);
  // Signed overflow when operand signs differ and result sign follows subtrahend.
  assign flags.ov = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ full_sum[7]);
endmodule // mrso_sub8

// >>> src/mrso_core.sv
`timescale 1ns/10ps
// Execution unit for rotate, subtract, skip, set, swap and table-read operations.
module mrso_core (
  input wire logic core_clk, // Core clock, 250 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic [3:0] avs_address, // Avalon byte address.
  input wire logic avs_read, // Avalon read strobe.
  input wire logic avs_write, // Avalon write strobe.
  input wire logic [31:0] avs_writedata, // Avalon write data.
  input wire logic [3:0] avs_byteenable, // Avalon byte enables.
  output logic [31:0] avs_readdata, // Avalon read data.
  output logic avs_waitrequest, // Avalon wait request.
  output mrso_pkg::mrso_mem_req_type mem_req, // Data memory request.
  input wire logic [7:0] mem_rdata, // Data memory byte, combinational read.
  output logic [10:0] prog_addr, // Program memory word address.
  output logic prog_rd, // Program memory read strobe.
  input wire logic [15:0] prog_rdata, // Program word, sampled at the edge ending prog_rd.
  output logic [7:0] table_read_high_byte, // Table-high register.
  output logic skip_pulse // One-cycle pulse when a skip is taken.
);

  // ****************************************
  // Architectural state
  // ****************************************
  logic [7:0] working_register_reg;
  logic [7:0] table_pointer_reg;
  logic [7:0] table_read_high_byte_reg;
  logic [10:0] pc_reg;
  mrso_pkg::mrso_flags_type flags_reg;
  mrso_pkg::mrso_state_type state_reg;
  mrso_pkg::mrso_op_type op_reg;
  logic [7:0] maddr_reg;
  logic [2:0] bitsel_reg;
  logic [7:0] imm_reg;
  logic skipped_reg;
  logic waitrequest_reg;
  logic [31:0] readdata_reg;
  mrso_pkg::mrso_mem_req_type mem_req_reg;
  logic prog_rd_reg;
  logic skip_pulse_reg;

  // ****************************************
  // Bus decode
  // ****************************************
  wire bus_req = (avs_read | avs_write) & waitrequest_reg;
  wire idle = (state_reg == mrso_pkg::ST_IDLE);
  wire wr_ctrl = avs_write & (avs_address == mrso_pkg::OFS_CTRL) & avs_byteenable[3];
  wire go = wr_ctrl & avs_writedata[mrso_pkg::CTRL_GO_BIT] & idle;
  wire wr_operand = avs_write & (avs_address == mrso_pkg::OFS_OPERAND) & avs_byteenable[0];
  wire wr_wreg = avs_write & (avs_address == mrso_pkg::OFS_WREG) & avs_byteenable[0];
  wire [7:0] status_bits = {2'b00, skipped_reg, ~idle, flags_reg.ov, flags_reg.ac, flags_reg.z,
    flags_reg.c};
  wire [31:0] rd_mux =
    (avs_address == mrso_pkg::OFS_CTRL) ? {24'h000000, 3'b000, op_reg} :
    (avs_address == mrso_pkg::OFS_OPERAND) ? {8'h00, table_pointer_reg, 5'h00, bitsel_reg,
      maddr_reg} :
    (avs_address == mrso_pkg::OFS_WREG) ? {16'h0000, table_read_high_byte_reg, working_register_reg} :
    (avs_address == mrso_pkg::OFS_STATUS) ? {24'h000000, status_bits} : 32'h00000000;

  // ****************************************
  // Datapath
  // ****************************************
  wire [7:0] m = mem_rdata;
  wire [7:0] bit_mask = 8'h01 << bitsel_reg;
  wire sel_bit = m[bitsel_reg];
  wire [7:0] m_dec = m - 8'h01;
  wire [7:0] m_inc = m + 8'h01;
  wire [7:0] rot_lc = {m[6:0], flags_reg.c};
  wire [7:0] rot_r = {m[0], m[7:1]};
  wire [7:0] rot_rc = {flags_reg.c, m[7:1]};
  wire [7:0] swapped = {m[3:0], m[7:4]};
  wire is_borrow = (op_reg == mrso_pkg::OP_SUBB_W) | (op_reg == mrso_pkg::OP_SUBB_M);
  wire [7:0] sub_operand = (op_reg == mrso_pkg::OP_SUB_I) ? imm_reg : m;
  // plain subtract uses carry-in of one.
  wire sub_cin = is_borrow ? flags_reg.c : 1'b1;
  wire [7:0] sub_diff;
  mrso_pkg::mrso_flags_type sub_flags;

  mrso_sub8 u_sub (
    .minuend(working_register_reg),
    .subtrahend(sub_operand),
    .carry_in(sub_cin),
    .diff(sub_diff),
    .flags(sub_flags)
  );

  // Per-operation results, decided combinationally.
  logic wr_mem;
  logic [7:0] mem_val;
  logic wr_w;
  logic [7:0] w_val;
  logic take_skip;
  mrso_pkg::mrso_flags_type flags_next;

  always_comb begin
    wr_mem = 1'b0;
    mem_val = m;
    wr_w = 1'b0;
    w_val = working_register_reg;
    take_skip = 1'b0;
    flags_next = flags_reg;
    case (op_reg)
      mrso_pkg::OP_RLC: begin
        wr_mem = 1'b1;
        mem_val = rot_lc;
        flags_next.c = m[7];
      end
      mrso_pkg::OP_RLC_W: begin
        wr_w = 1'b1;
        w_val = rot_lc;
        flags_next.c = m[7];
      end
      mrso_pkg::OP_RR: begin
        wr_mem = 1'b1;
        mem_val = rot_r;
      end
      mrso_pkg::OP_RR_W: begin
        wr_w = 1'b1;
        w_val = rot_r;
      end
      mrso_pkg::OP_RRC: begin
        wr_mem = 1'b1;
        mem_val = rot_rc;
        flags_next.c = m[0];
      end
      mrso_pkg::OP_RRC_W: begin
        wr_w = 1'b1;
        w_val = rot_rc;
        flags_next.c = m[0];
      end
      mrso_pkg::OP_SUBB_W, mrso_pkg::OP_SUB_W, mrso_pkg::OP_SUB_I: begin
        wr_w = 1'b1;
        w_val = sub_diff;
        flags_next = sub_flags;
      end
      mrso_pkg::OP_SUBB_M, mrso_pkg::OP_SUB_M: begin
        wr_mem = 1'b1;
        mem_val = sub_diff;
        flags_next = sub_flags;
      end
      mrso_pkg::OP_DSZ_M: begin
        wr_mem = 1'b1;
        mem_val = m_dec;
        take_skip = (m_dec == mrso_pkg::BYTE_ZERO);
      end
      mrso_pkg::OP_DSZ_W: begin
        wr_w = 1'b1;
        w_val = m_dec;
        take_skip = (m_dec == mrso_pkg::BYTE_ZERO);
      end
      mrso_pkg::OP_SETB: begin
        wr_mem = 1'b1;
        mem_val = mrso_pkg::BYTE_ONES;
      end
      mrso_pkg::OP_SETBIT: begin
        wr_mem = 1'b1;
        mem_val = m | bit_mask;
      end
      mrso_pkg::OP_ISZ_M: begin
        wr_mem = 1'b1;
        mem_val = m_inc;
        take_skip = (m_inc == mrso_pkg::BYTE_ZERO);
      end
      mrso_pkg::OP_ISZ_W: begin
        wr_w = 1'b1;
        w_val = m_inc;
        take_skip = (m_inc == mrso_pkg::BYTE_ZERO);
      end
      mrso_pkg::OP_SKBS: begin
        take_skip = sel_bit;
      end
      mrso_pkg::OP_SWAP_M: begin
        wr_mem = 1'b1;
        mem_val = swapped;
      end
      mrso_pkg::OP_SWAP_W: begin
        wr_w = 1'b1;
        w_val = swapped;
      end
      mrso_pkg::OP_SKZ: begin
        take_skip = (m == mrso_pkg::BYTE_ZERO);
      end
      mrso_pkg::OP_CPSKZ: begin
        wr_w = 1'b1;
        w_val = m;
        take_skip = (m == mrso_pkg::BYTE_ZERO);
      end
      mrso_pkg::OP_SKBC: begin
        take_skip = ~sel_bit;
      end
      default: begin
        wr_mem = 1'b0;
      end
    endcase
  end

  // current page is the top bits of the program counter.
  wire [10:0] tbl_addr = {pc_reg[10:8], table_pointer_reg};
  // PC step: two words when the skip is taken, one otherwise.
  wire [10:0] pc_step = take_skip ? 11'h002 : 11'h001;

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= mrso_pkg::ST_IDLE;
      op_reg <= mrso_pkg::OP_NONE;
      maddr_reg <= 8'h00;
      bitsel_reg <= 3'h0;
      imm_reg <= 8'h00;
      pc_reg <= mrso_pkg::PC_RESET;
      skipped_reg <= 1'b0;
      skip_pulse_reg <= 1'b0;
      prog_rd_reg <= 1'b0;
    end else begin
      skip_pulse_reg <= 1'b0;
      prog_rd_reg <= 1'b0;
      case (state_reg)
        mrso_pkg::ST_IDLE: begin
          if (go) begin
            op_reg <= mrso_pkg::mrso_op_type'(avs_writedata[mrso_pkg::CTRL_OP_LSB +: 5]);
            bitsel_reg <= avs_writedata[mrso_pkg::CTRL_BIT_LSB +: 3];
            imm_reg <= avs_writedata[mrso_pkg::CTRL_IMM_LSB +: 8];
            state_reg <= (avs_writedata[mrso_pkg::CTRL_OP_LSB +: 5] == mrso_pkg::OP_TBRD) ?
              mrso_pkg::ST_TBL : mrso_pkg::ST_EXEC;
            prog_rd_reg <= (avs_writedata[mrso_pkg::CTRL_OP_LSB +: 5] == mrso_pkg::OP_TBRD);
          end
          if (wr_operand) begin
            maddr_reg <= avs_writedata[7:0];
          end
        end
        mrso_pkg::ST_EXEC: begin
          skipped_reg <= take_skip;
          pc_reg <= pc_reg + pc_step;
          skip_pulse_reg <= take_skip;
          // a taken skip spends a dummy cycle.
          state_reg <= take_skip ? mrso_pkg::ST_DUMMY : mrso_pkg::ST_IDLE;
        end
        mrso_pkg::ST_TBL: begin
          skipped_reg <= 1'b0;
          pc_reg <= pc_reg + 11'h001;
          state_reg <= mrso_pkg::ST_IDLE;
        end
        mrso_pkg::ST_DUMMY: begin
          state_reg <= mrso_pkg::ST_IDLE;
        end
        default: begin
          state_reg <= mrso_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Register updates from execution or software writes.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      working_register_reg <= mrso_pkg::WREG_RESET;
      table_pointer_reg <= mrso_pkg::TABLE_POINTER_RESET;
      table_read_high_byte_reg <= mrso_pkg::TABLE_READ_HIGH_BYTE_RESET;
      flags_reg <= '0;
      mem_req_reg <= '0;
    end else begin
      mem_req_reg.we <= 1'b0;
      if (state_reg == mrso_pkg::ST_EXEC) begin
        flags_reg <= flags_next;
        if (wr_w) begin
          working_register_reg <= w_val;
        end
        mem_req_reg <= '{we: wr_mem, addr: maddr_reg, wdata: mem_val};
      end else if (state_reg == mrso_pkg::ST_TBL) begin
        // low byte to memory, high byte to table-high.
        table_read_high_byte_reg <= prog_rdata[15:8];
        mem_req_reg <= '{we: 1'b1, addr: maddr_reg, wdata: prog_rdata[7:0]};
      end else begin
        mem_req_reg.addr <= maddr_reg;
        if (idle & wr_wreg) begin
          working_register_reg <= avs_writedata[7:0];
        end
        if (idle & wr_operand & avs_byteenable[2]) begin
          table_pointer_reg <= avs_writedata[23:16];
        end
      end
    end
  end

  // Bus answers one cycle after the request is seen; wait request stays high otherwise.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      waitrequest_reg <= 1'b1;
      readdata_reg <= 32'h00000000;
    end else begin
      waitrequest_reg <= ~bus_req;
      readdata_reg <= rd_mux;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = waitrequest_reg;
  // Memory address is held so the combinational read returns the operand during EXEC.
  assign mem_req = mem_req_reg;
  assign prog_addr = tbl_addr;
  assign prog_rd = prog_rd_reg;
  assign table_read_high_byte = table_read_high_byte_reg;
  assign skip_pulse = skip_pulse_reg;

endmodule // mrso_core

// >>> dv/mrso_core_monitor.sv
`timescale 1ns/10ps
// ****************************************
// Port-level checker for the execution unit
// ****************************************
module mrso_core_monitor (
  input wire logic core_clk, // Core clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic [3:0] avs_address, // Bus address.
  input wire logic avs_read, // Bus read strobe.
  input wire logic avs_write, // Bus write strobe.
  input wire logic [31:0] avs_writedata, // Bus write data.
  input wire logic [3:0] avs_byteenable, // Bus byte enables.
  input wire logic [31:0] avs_readdata, // Bus read data.
  input wire logic avs_waitrequest, // Bus wait request.
  input mrso_pkg::mrso_mem_req_type mem_req, // Data memory request.
  input wire logic [7:0] mem_rdata, // Data memory byte.
  input wire logic [10:0] prog_addr, // Program word address.
  input wire logic prog_rd, // Program read strobe.
  input wire logic [15:0] prog_rdata, // Program word.
  input wire logic [7:0] table_read_high_byte, // Table-high register.
  input wire logic skip_pulse // Skip taken.
);
  default clocking mon_cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // Decode of an accepted go write; operand byte is captured because results land later.
  wire go_hit = avs_write && !avs_waitrequest && avs_address == mrso_pkg::OFS_CTRL
    && avs_writedata[31];
  wire opnd_hit = avs_write && !avs_waitrequest && avs_address == mrso_pkg::OFS_OPERAND;
  wire [4:0] go_op = avs_writedata[4:0];
  wire [2:0] go_bit = avs_writedata[10:8];
  logic [7:0] mem_reg;
  logic [2:0] bit_reg;

  // Snapshot of the operand byte and bit select at the go edge.
  always_ff @(posedge core_clk) begin
    if (go_hit) begin
      mem_reg <= mem_rdata;
      bit_reg <= go_bit;
    end
  end

  sequence go_s;
    go_hit;
  endsequence
  sequence tbl_s;
    prog_rd ##[1:2] mem_req.we;
  endsequence

  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");
  wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait request low for more than one cycle");
  skip_single_a: assert property (skip_pulse |=> !skip_pulse)
    else $error("skip pulse longer than one cycle");
  set_byte_a: assert property (go_s ##0 go_op == mrso_pkg::OP_SETB
    |-> ##[1:3] (mem_req.we && mem_req.wdata == mrso_pkg::BYTE_ONES))
    else $error("byte set did not write all ones");
  set_bit_a: assert property (go_s ##0 go_op == mrso_pkg::OP_SETBIT
    |-> ##[1:3] (mem_req.we && mem_req.wdata == (mem_reg | (8'h01 << bit_reg))))
    else $error("bit set wrote a wrong byte");
  skip_set_a: assert property (go_s ##0 (go_op == mrso_pkg::OP_SKBS
    && mem_rdata[go_bit]) |-> ##[1:3] skip_pulse)
    else $error("set bit did not skip");
  skip_clear_a: assert property (go_s ##0 (go_op == mrso_pkg::OP_SKBC
    && !mem_rdata[go_bit]) |-> ##[1:3] skip_pulse)
    else $error("clear bit did not skip");
  no_skip_a: assert property (go_s ##0 (
    (go_op == mrso_pkg::OP_SKBS && !mem_rdata[go_bit])
    || (go_op == mrso_pkg::OP_SKZ && mem_rdata != 8'h00)) |=> !skip_pulse [*4])
    else $error("skip taken with condition false");
  test_no_write_a: assert property (go_s ##0 (go_op == mrso_pkg::OP_SKZ
    || go_op == mrso_pkg::OP_SKBS || go_op == mrso_pkg::OP_SKBC) |=> !mem_req.we [*4])
    else $error("skip test wrote memory");
  tbl_strobe_a: assert property (go_s ##0 go_op == mrso_pkg::OP_TBRD
    |-> ##[0:2] prog_rd)
    else $error("table read did not strobe program memory");
  tbl_low_a: assert property (tbl_s |-> mem_req.wdata == prog_rdata[7:0])
    else $error("table low byte wrong");
  tbl_high_a: assert property (tbl_s |=> table_read_high_byte == prog_rdata[15:8])
    else $error("table high byte wrong");
  tbl_ptr_a: assert property (opnd_hit
    |=> prog_addr[7:0] == $past(avs_writedata[23:16]))
    else $error("table pointer not on program address");
  mem_addr_a: assert property (opnd_hit
    |=> mem_req.addr == $past(avs_writedata[7:0]))
    else $error("memory address not taken from operand");
endmodule // mrso_core_monitor

// >>> dv/mrso_core_tb.sv
`timescale 1ns/10ps
module mrso_core_tb;
  // One table case: operation, {mem, wreg, expected wreg, expected mem}, {carry, bit}.
  typedef struct {
    mrso_pkg::mrso_op_type op;
    logic [31:0] bytes;
    logic [3:0] cb;
    logic [3:0] ef;
    logic es;
  } mrso_row_type;

  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  mrso_pkg::mrso_mem_req_type mem_req;
  logic [7:0] mem_rdata;
  logic [10:0] prog_addr;
  logic prog_rd;
  logic [15:0] prog_rdata;
  logic [7:0] table_read_high_byte;
  logic skip_pulse;
  logic [7:0] dmem [0:255];
  int errors = 0;
  int cmp_count = 0;
  int skip_cnt = 0;
  mrso_row_type rows [29];

  // ****************************************
  // Clock, design and memory models
  // ****************************************
  always #2 core_clk = ~core_clk;

  mrso_core mrso_core_i (
    .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .prog_addr(prog_addr), .prog_rd(prog_rd),
    .prog_rdata(prog_rdata), .table_read_high_byte(table_read_high_byte),
    .skip_pulse(skip_pulse)
  );

  // Both memories read combinationally, since the unit takes the program word at the
  // edge that ends its read strobe; the word depends on the low address only.
  assign mem_rdata = dmem[mem_req.addr];
  assign prog_rdata = {prog_addr[7:0] ^ 8'ha5, ~prog_addr[7:0]};
  always @(posedge core_clk) begin
    if (mem_req.we === 1'b1) dmem[mem_req.addr] <= mem_req.wdata;
    if (skip_pulse === 1'b1) skip_cnt <= skip_cnt + 1;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tally_and_finish();
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One bus cycle; the request is held until wait request is seen low.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Start an operation and poll until the unit is idle again.
  task automatic run(input mrso_pkg::mrso_op_type op, input logic [2:0] b, input logic [7:0] imm);
    logic [31:0] q;
    bus(1'b1, mrso_pkg::OFS_CTRL, {1'b1, 7'h00, imm, 5'h00, b, 3'h0, op}, q);
    do bus(1'b0, mrso_pkg::OFS_STATUS, 32'h0, q); while (q[mrso_pkg::ST_BUSY] !== 1'b0);
  endtask

  // Carry has no software write, so a subtract sets it up.
  task automatic prep(input logic c, input logic [7:0] w);
    logic [31:0] q;
    bus(1'b1, mrso_pkg::OFS_WREG, 32'h0000_0010, q);
    run(mrso_pkg::OP_SUB_I, 3'h0, c ? 8'h01 : 8'h20);
    bus(1'b0, mrso_pkg::OFS_WREG, 32'h0, q);
    chk("imm_wreg", c ? 8'h0f : 8'hf0, q[7:0]);
    bus(1'b0, mrso_pkg::OFS_STATUS, 32'h0, q);
    chk("imm_flags", c ? 4'h1 : 4'h4, q[3:0]);
    bus(1'b1, mrso_pkg::OFS_WREG, {24'h000000, w}, q);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] q;
    int s;
    repeat (3) @(posedge core_clk);
    chk("wait_in_reset", 1'b1, avs_waitrequest);
    arst_n <= 1'b1;
    bus(1'b0, mrso_pkg::OFS_WREG, 32'h0, q);
    chk("reset_wreg", 32'h0, q);
    bus(1'b0, mrso_pkg::OFS_STATUS, 32'h0, q);
    chk("reset_status", 32'h0, q);
    bus(1'b0, 4'h2, 32'h0, q);
    chk("unmapped", 32'h0, q);
    rows = '{
      '{mrso_pkg::OP_RLC, 32'h813c3c02, 4'h0, 4'h5, 1'b0},
      '{mrso_pkg::OP_RLC, 32'h403c3c81, 4'h8, 4'h0, 1'b0},
      '{mrso_pkg::OP_RLC_W, 32'h813c0381, 4'h8, 4'h1, 1'b0},
      '{mrso_pkg::OP_RR, 32'h013c3c80, 4'h8, 4'h1, 1'b0},
      '{mrso_pkg::OP_RR_W, 32'h023c0102, 4'h0, 4'h4, 1'b0},
      '{mrso_pkg::OP_RRC, 32'h013c3c00, 4'h0, 4'h5, 1'b0},
      '{mrso_pkg::OP_RRC_W, 32'h023c8102, 4'h8, 4'h0, 1'b0},
      '{mrso_pkg::OP_SUBB_W, 32'h20502f20, 4'h0, 4'h1, 1'b0},
      '{mrso_pkg::OP_SUBB_M, 32'h0180807f, 4'h8, 4'h9, 1'b0},
      '{mrso_pkg::OP_SUB_W, 32'h2010f020, 4'h8, 4'h4, 1'b0},
      '{mrso_pkg::OP_SUB_M, 32'h33333300, 4'h0, 4'h7, 1'b0},
      '{mrso_pkg::OP_SUB_I, 32'h007f8000, 4'h0, 4'hc, 1'b0},
      '{mrso_pkg::OP_DSZ_M, 32'h013c3c00, 4'h8, 4'h1, 1'b1},
      '{mrso_pkg::OP_DSZ_M, 32'h003c3cff, 4'h0, 4'h4, 1'b0},
      '{mrso_pkg::OP_DSZ_W, 32'h013c0001, 4'h0, 4'h4, 1'b1},
      '{mrso_pkg::OP_SETB, 32'h123c3cff, 4'h8, 4'h1, 1'b0},
      '{mrso_pkg::OP_SETBIT, 32'h003c3c80, 4'h7, 4'h4, 1'b0},
      '{mrso_pkg::OP_ISZ_M, 32'hff3c3c00, 4'h8, 4'h1, 1'b1},
      '{mrso_pkg::OP_ISZ_W, 32'hfe3cfffe, 4'h0, 4'h4, 1'b0},
      '{mrso_pkg::OP_SKBS, 32'h083c3c08, 4'hb, 4'h1, 1'b1},
      '{mrso_pkg::OP_SKBS, 32'hf73c3cf7, 4'h3, 4'h4, 1'b0},
      '{mrso_pkg::OP_SWAP_M, 32'h1e3c3ce1, 4'h0, 4'h4, 1'b0},
      '{mrso_pkg::OP_SWAP_W, 32'h1e3ce11e, 4'h8, 4'h1, 1'b0},
      '{mrso_pkg::OP_SKZ, 32'h003c3c00, 4'h8, 4'h1, 1'b1},
      '{mrso_pkg::OP_SKZ, 32'h013c3c01, 4'h0, 4'h4, 1'b0},
      '{mrso_pkg::OP_CPSKZ, 32'h003c0000, 4'h8, 4'h1, 1'b1},
      '{mrso_pkg::OP_CPSKZ, 32'h5a3c5a5a, 4'h0, 4'h4, 1'b0},
      '{mrso_pkg::OP_SKBC, 32'hfe3c3cfe, 4'h8, 4'h1, 1'b1},
      '{mrso_pkg::OP_SKBC, 32'h013c3c01, 4'h0, 4'h4, 1'b0}
    };
    bus(1'b1, mrso_pkg::OFS_OPERAND, 32'h0037_0021, q);
    // Each row checks register, flags with the skip status bit, memory byte and skip count.
    foreach (rows[i]) begin
      dmem[8'h21] = rows[i].bytes[31:24];
      prep(rows[i].cb[3], rows[i].bytes[23:16]);
      s = skip_cnt;
      run(rows[i].op, rows[i].cb[2:0], 8'hff);
      bus(1'b0, mrso_pkg::OFS_WREG, 32'h0, q);
      chk("wreg", rows[i].bytes[15:8], q[7:0]);
      bus(1'b0, mrso_pkg::OFS_STATUS, 32'h0, q);
      chk("flags", {rows[i].es, 1'b0, rows[i].ef}, q[5:0]);
      chk("mem", rows[i].bytes[7:0], dmem[8'h21]);
      chk("skips", rows[i].es, skip_cnt - s);
    end
    // Table read through pointer 0x37: low byte to memory, high byte to the table register.
    prep(1'b1, 8'h3c);
    run(mrso_pkg::OP_TBRD, 3'h0, 8'hff);
    bus(1'b0, mrso_pkg::OFS_WREG, 32'h0, q);
    chk("tbl_word", 16'h923c, q[15:0]);
    chk("tbl_port", 8'h92, table_read_high_byte);
    chk("tbl_mem", 8'hc8, dmem[8'h21]);
    bus(1'b0, mrso_pkg::OFS_STATUS, 32'h0, q);
    chk("tbl_flags", 4'h1, q[3:0]);
    // A reset in mid-run must clear table-high, working and status registers again.
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("rst_mid_high", 8'h00, table_read_high_byte);
    arst_n <= 1'b1;
    bus(1'b0, mrso_pkg::OFS_WREG, 32'h0, q);
    chk("rst_mid_wreg", 32'h0, q);
    bus(1'b0, mrso_pkg::OFS_STATUS, 32'h0, q);
    chk("rst_mid_status", 32'h0, q);
    tally_and_finish();
  end

  // Watchdog well beyond the roughly one thousand cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    tally_and_finish();
  end
endmodule // mrso_core_tb

bind mrso_core mrso_core_monitor mrso_core_monitor_i (
  .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mem_req(mem_req),
  .mem_rdata(mem_rdata), .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_rdata(prog_rdata),
  .table_read_high_byte(table_read_high_byte), .skip_pulse(skip_pulse)
);
